// >>> afc_pkg.sv
// Package for the automatic flow-control engine
package afc_pkg;
    // Register map
    localparam logic [11:0] CFG_OFFSET    = 12'h0AC;
    localparam logic [11:0] STATUS_OFFSET = 12'h0C0;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Field positions of the configuration word
    localparam int HI_LSB   = 16;
    localparam int LO_LSB   = 8;
    localparam int DUR_LSB  = 4;
    localparam int MULT_BIT = 3;
    localparam int BRD_BIT  = 2;
    localparam int OWN_BIT  = 1;
    localparam int ANY_BIT  = 0;
    localparam int UNIT_SHIFT = 6;  // Thresholds count 64-byte units

    // Status word bit positions
    localparam int ST_PAUSED = 0;
    localparam int ST_JAM    = 1;
    localparam int ST_HIGH   = 2;
    localparam int ST_LOW    = 3;

    // Jam timing, counted in 100 ns ticks
    localparam int CLK_NS       = 10;
    localparam int JAM_TICK_NS  = 100;
    localparam int JAM_TICK_CYC = (JAM_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int JAM_W        = 13;
    localparam logic [JAM_W-1:0] JAM_10M_EXTRA = 13'h0016;  // 2.2 us
    localparam logic [JAM_W-1:0] JAM_TENTHS [16] = '{
        13'h0032, 13'h0064, 13'h0096, 13'h00FA, 13'h01F4, 13'h03E8, 13'h05DC, 13'h07D0,
        13'h09C4, 13'h0BB8, 13'h0DAC, 13'h0FA0, 13'h1194, 13'h1388, 13'h157C, 13'h1770};

    typedef struct packed {
        logic [7:0] reserved;
        logic [7:0] flowHighThreshold;
        logic [7:0] flowLowThreshold;
        logic [3:0] jamDurationSel;
        logic       jamOnGroupFrames;
        logic       jamOnAllStationFrames;
        logic       jamOnOwnAddress;
        logic       flowOnEveryFrame;
    } afc_conf_t;

    // Receive-side frame events from the MAC, one-cycle pulses
    typedef struct packed {
        logic preamble;
        logic addrDecoded;
        logic multicast;
        logic broadcast;
        logic ownAddress;
    } afc_rx_t;

    typedef enum logic [0:0] {ARMED, PAUSED} afc_state_t;

    function automatic logic [JAM_W-1:0] jamTicks(input logic [3:0] sel, input logic speed100);
        jamTicks = speed100 ? JAM_TENTHS[sel] : JAM_TENTHS[sel] + JAM_10M_EXTRA;
    endfunction : jamTicks
endpackage : afc_pkg

// >>> afc_flow_control.sv
// Automatic flow-control engine with AXI4-Lite configuration
// Summary of operation
// - No pause frame or back pressure while the transmitter is disabled.
// - High threshold in bits 23:16, 64-byte units, triggers flow control per bits 3:0.
// - Full duplex: one pause frame per high event, carrying the MAC pause time.
// - Half duplex past high threshold: jam each matching frame for the duration.
// - Low threshold in bits 15:8; falling below it sends a zero-time pause.
// - Zero-time pause only after a high event actually sent a pause frame.
// - Bits 7:4 set jam duration; unused in full duplex.
// - Bit 3 jams multicast frames past threshold; no effect in full duplex.
// - Bit 2 jams broadcast frames past threshold; no effect in full duplex.
// - Bit 1 jams own-address frames past threshold; no effect in full duplex.
// - Bit 0 reacts to any frame; enables full-duplex flow control.
// - Half duplex any-frame: jam on next valid preamble, no address decode.
// - Full duplex any-frame: request pause immediately on reaching threshold.
// - Any-frame bit overrides the multicast, broadcast and own-address bits.
// - Duration codes map 5 us to 600 us; 10 Mb/s adds 2.2 us.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module afc_flow_control #(
    parameter int LEVEL_W = 14,
    parameter int ADDR_W  = 12
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // AXI4-Lite write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // MAC state
    input  wire logic [LEVEL_W-1:0]  rxFifoLevel,
    input  wire logic                txEnable,
    input  wire logic                fullDuplex,
    input  wire logic                speed100,
    input  wire logic [15:0]         pauseTimeValue,
    input  wire logic                swPauseReq,
    input  wire afc_pkg::afc_rx_t    rxEvent,
    // Requests to the MAC
    output logic                     pauseReq,
    output logic [15:0]              pauseTime,
    output logic                     jamActive
);
    afc_pkg::afc_conf_t  cfg;
    afc_pkg::afc_conf_t  next_cfg;
    afc_pkg::afc_state_t state;
    logic [ADDR_W-1:0]   wrAddr;
    logic [31:0]         wrData;
    logic [3:0]          wrStrb;
    logic                awHeld;
    logic                wHeld;
    logic                highReached;
    logic                belowLow;
    logic                frameMatch;
    logic                autoPause;
    logic                zeroPause;
    logic                jamStart;
    logic [7:0]          tickCount;
    logic                tick;
    logic [afc_pkg::JAM_W-1:0] jamCount;

    // Threshold comparison in bytes
    assign highReached = rxFifoLevel >= LEVEL_W'({cfg.flowHighThreshold, 6'h00});
    assign belowLow    = rxFifoLevel <  LEVEL_W'({cfg.flowLowThreshold, 6'h00});

    // Frame selection for back pressure
    always_comb
    begin
        if (cfg.flowOnEveryFrame)
            frameMatch = rxEvent.preamble;
        else
            frameMatch = rxEvent.addrDecoded &&
                ((cfg.jamOnGroupFrames && rxEvent.multicast) ||
                 (cfg.jamOnAllStationFrames && rxEvent.broadcast) ||
                 (cfg.jamOnOwnAddress && rxEvent.ownAddress));
    end

    assign autoPause = fullDuplex && txEnable && cfg.flowOnEveryFrame && state == afc_pkg::ARMED
                       && highReached;
    assign zeroPause = fullDuplex && txEnable && state == afc_pkg::PAUSED && belowLow;
    assign jamStart  = !fullDuplex && txEnable && highReached && frameMatch;

    // High-event state
    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= afc_pkg::ARMED;
        else if (autoPause)
            state <= afc_pkg::PAUSED;
        else if (zeroPause || !cfg.flowOnEveryFrame)
            state <= afc_pkg::ARMED;
    end

    // Pause requests to the MAC
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pauseReq  <= 1'b0;
            pauseTime <= 16'h0000;
        end
        else
        begin
            pauseReq <= autoPause || zeroPause || (swPauseReq && txEnable);
            if (zeroPause)
                pauseTime <= 16'h0000;
            else if (autoPause || swPauseReq)
                pauseTime <= pauseTimeValue;
        end
    end

    // 100 ns tick for the jam timer
    always_ff @(posedge mclk)
    begin
        if (rst || tick)
            tickCount <= 8'h00;
        else
            tickCount <= tickCount + 8'h01;
    end
    assign tick = tickCount == 8'(afc_pkg::JAM_TICK_CYC - 1);

    // Back-pressure timer
    always_ff @(posedge mclk)
    begin
        if (rst || fullDuplex || !txEnable)
        begin
            jamCount  <= '0;
            jamActive <= 1'b0;
        end
        else if (jamStart)
        begin
            jamCount  <= afc_pkg::jamTicks(cfg.jamDurationSel, speed100);
            jamActive <= 1'b1;
        end
        else if (tick && jamCount != '0)
        begin
            jamCount  <= jamCount - 1'b1;
            jamActive <= jamCount != afc_pkg::JAM_W'(1);
        end
    end

    // Configuration write with byte strobes
    always_comb
    begin
        next_cfg = cfg;
        for (int i = 0; i < 3; i++)
            if (wrStrb[i])
                next_cfg[8*i +: 8] = wrData[8*i +: 8];
        next_cfg.reserved = 8'h00;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            cfg <= afc_pkg::CFG_RESET;
        else if (awHeld && wHeld && !bvalid && wrAddr == ADDR_W'(afc_pkg::CFG_OFFSET))
            cfg <= next_cfg;
    end

    // AXI4-Lite write channels
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= afc_pkg::RESP_OKAY;
            wrAddr  <= '0;
            wrData  <= 32'h0000_0000;
            wrStrb  <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                wrAddr  <= awaddr;
                awHeld  <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wrData <= wdata;
                wrStrb <= wstrb;
                wHeld  <= 1'b1;
                wready <= 1'b0;
            end
            if (awHeld && wHeld && !bvalid)
            begin
                bvalid <= 1'b1;
                bresp  <= (wrAddr == ADDR_W'(afc_pkg::CFG_OFFSET)) ? afc_pkg::RESP_OKAY : afc_pkg::RESP_SLVERR;
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= afc_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= afc_pkg::RESP_OKAY;
            rdata   <= 32'h0000_0000;
            if (araddr == ADDR_W'(afc_pkg::CFG_OFFSET))
                rdata <= cfg;
            else if (araddr == ADDR_W'(afc_pkg::STATUS_OFFSET))
            begin
                rdata[afc_pkg::ST_PAUSED] <= state == afc_pkg::PAUSED;
                rdata[afc_pkg::ST_JAM]    <= jamActive;
                rdata[afc_pkg::ST_HIGH]   <= highReached;
                rdata[afc_pkg::ST_LOW]    <= belowLow;
            end
            else
                rresp <= afc_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Checks
    property p_noPauseTxOff;
        @(posedge mclk) disable iff (rst) pauseReq |-> $past(txEnable);
    endproperty
    a_noPauseTxOff: assert property (p_noPauseTxOff) else $error("pause while transmitter off");

    property p_noJamTxOff;
        @(posedge mclk) disable iff (rst) !txEnable |=> !jamActive;
    endproperty
    a_noJamTxOff: assert property (p_noJamTxOff) else $error("jam while transmitter off");

    property p_singlePause;
        @(posedge mclk) disable iff (rst)
            (pauseReq && pauseTime != 16'h0000 && !$past(swPauseReq)) |-> $past(state) == afc_pkg::ARMED
            && state == afc_pkg::PAUSED;
    endproperty
    a_singlePause: assert property (p_singlePause) else $error("repeated pause frame");

    property p_zeroAfterHigh;
        @(posedge mclk) disable iff (rst)
            zeroPause |=> pauseReq && pauseTime == 16'h0000 && $past(state) == afc_pkg::PAUSED;
    endproperty
    a_zeroAfterHigh: assert property (p_zeroAfterHigh) else $error("zero pause out of order");

    property p_zeroBelowLow;
        @(posedge mclk) disable iff (rst)
            $past(state) == afc_pkg::PAUSED && state == afc_pkg::ARMED && $past(cfg.flowOnEveryFrame)
            |-> $past(belowLow) && pauseReq && pauseTime == 16'h0000;
    endproperty
    a_zeroBelowLow: assert property (p_zeroBelowLow) else $error("zero pause without low level");

    property p_fullDuplexPause;
        @(posedge mclk) disable iff (rst)
            fullDuplex && txEnable && cfg.flowOnEveryFrame && state == afc_pkg::ARMED && highReached
            |=> pauseReq && pauseTime == $past(pauseTimeValue);
    endproperty
    a_fullDuplexPause: assert property (p_fullDuplexPause) else $error("missing pause request");

    property p_noJamFull;
        @(posedge mclk) disable iff (rst) fullDuplex |=> !jamActive;
    endproperty
    a_noJamFull: assert property (p_noJamFull) else $error("jam in full duplex");

    property p_jamPreamble;
        @(posedge mclk) disable iff (rst)
            !fullDuplex && txEnable && highReached && cfg.flowOnEveryFrame && rxEvent.preamble
            |=> jamActive;
    endproperty
    a_jamPreamble: assert property (p_jamPreamble) else $error("no jam on preamble");

    property p_jamOwn;
        @(posedge mclk) disable iff (rst)
            !fullDuplex && txEnable && highReached && cfg.jamOnOwnAddress && rxEvent.addrDecoded
            && rxEvent.ownAddress |=> jamActive;
    endproperty
    a_jamOwn: assert property (p_jamOwn) else $error("no jam on own address");

    property p_jamLength;
        @(posedge mclk) disable iff (rst)
            $rose(jamActive) |-> jamCount == afc_pkg::jamTicks($past(cfg.jamDurationSel), $past(speed100));
    endproperty
    a_jamLength: assert property (p_jamLength) else $error("wrong jam duration");
endmodule : afc_flow_control

// >>> afc_mac_model.sv
// Behavioural MAC partner: counts pause requests, sends receive events
`timescale 1ns/1ps
module afc_mac_model (
    // Clock
    input  wire logic        mclk,
    // Pause requests from the engine
    input  wire logic        pauseReq,
    input  wire logic [15:0] pauseTime,
    // Receive events to the engine
    output afc_pkg::afc_rx_t rxEvent
);
    int          pauseCount = 0;
    logic [15:0] lastTime   = 16'h0000;

    initial rxEvent = '0;

    // Pause frame taken by the MAC
    always @(posedge mclk)
    begin
        if (pauseReq === 1'b1)
        begin
            pauseCount++;
            lastTime = pauseTime;
        end
    end

    // Preamble pulse, then decoded header; class bits junk outside decode
    task automatic sendFrame(input logic [2:0] kind);
        @(posedge mclk);
        rxEvent <= {1'h1, 1'h0, ~kind};
        @(posedge mclk);
        rxEvent <= {1'h0, 1'h1, kind};
        @(posedge mclk);
        rxEvent <= {2'h0, ~kind};
    endtask : sendFrame
endmodule : afc_mac_model

// >>> auto_flow_control_bench.sv
// Self-checking bench for the automatic flow-control engine
`timescale 1ns/1ps
module auto_flow_control_bench;
    localparam logic [11:0] CFG = afc_pkg::CFG_OFFSET;
    localparam logic [7:0] CFGB [7] = '{8'h08, 8'h04, 8'h02, 8'h04, 8'h11, 8'h31, 8'h01};
    localparam logic [2:0] KIND [7] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h0, 3'h0, 3'h0};
    localparam logic       SPD  [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
    localparam logic       TXE  [7] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    localparam int         TICKS [7] = '{50, 50, 50, 0, 122, 250, 0};

    logic mclk = 1'h0, rst = 1'h1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, pauseReq, jamActive;
    logic [1:0] bresp, rresp, r;
    logic [13:0] rxFifoLevel = 14'h0000;
    logic txEnable = 1'h1, fullDuplex = 1'h0, speed100 = 1'h1, swPauseReq = 1'h0;
    logic [15:0] pauseTimeValue = 16'h0000, pauseTime;
    afc_pkg::afc_rx_t rxEvent;
    int errors = 0, check_count = 0, n, i;

    always #5 mclk = ~mclk;

    afc_flow_control dut (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .rxFifoLevel, .txEnable, .fullDuplex, .speed100, .pauseTimeValue, .swPauseReq, .rxEvent,
        .pauseReq, .pauseTime, .jamActive);

    afc_mac_model mac (.mclk, .pauseReq, .pauseTime, .rxEvent);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic idle(input int c);
        repeat (c) @(posedge mclk);
    endtask : idle

    task automatic axiWrite(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                            input logic [1:0] er);
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'h0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'h0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'h0;
        chk(bresp, er);
    endtask : axiWrite

    task automatic axiRead(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'h0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'h0;
        v = rdata;
        rs = rresp;
    endtask : axiRead

    // Cycles of back pressure following a frame
    task automatic jamLen(output int c);
        int k;
        c = 0;
        for (k = 0; k < 20 && jamActive !== 1'b1; k++) @(posedge mclk);
        while (jamActive === 1'b1 && c < 7000)
        begin
            @(posedge mclk);
            c++;
        end
    endtask : jamLen

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #200us;
        errors++;
        stop_test();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        // Register access
        axiRead(CFG, d, r);
        chk(d, afc_pkg::CFG_RESET);
        axiWrite(CFG, 32'hFF04_0201, 4'hF, afc_pkg::RESP_OKAY);
        axiWrite(CFG, 32'h0000_0300, 4'h2, afc_pkg::RESP_OKAY);
        axiRead(CFG, d, r);
        chk(d, 32'h0004_0301);
        axiWrite(afc_pkg::STATUS_OFFSET, 32'h0, 4'hF, afc_pkg::RESP_SLVERR);
        axiRead(12'h0B0, d, r);
        chk(r, afc_pkg::RESP_SLVERR);
        $display("TEST registers done");
        // Full duplex pause frames
        fullDuplex <= 1'h1;
        pauseTimeValue <= 16'h1234;
        rxFifoLevel <= 14'h00FF;
        idle(20);
        chk(mac.pauseCount, 0);
        rxFifoLevel <= 14'h0100;
        mac.sendFrame(3'h4);
        idle(20);
        chk(mac.pauseCount, 1);
        chk(mac.lastTime, 32'h1234);
        chk(jamActive, 1'h0);
        axiRead(afc_pkg::STATUS_OFFSET, d, r);
        chk(d, 32'h0000_0005);
        chk(r, afc_pkg::RESP_OKAY);
        rxFifoLevel <= 14'h00C0;
        idle(20);
        chk(mac.pauseCount, 1);
        rxFifoLevel <= 14'h00BF;
        idle(20);
        chk(mac.pauseCount, 2);
        chk(mac.lastTime, 32'h0);
        rxFifoLevel <= 14'h0100;
        idle(20);
        chk(mac.pauseCount, 3);
        rxFifoLevel <= 14'h0000;
        idle(20);
        txEnable <= 1'h0;
        rxFifoLevel <= 14'h0100;
        swPauseReq <= 1'h1;
        idle(1);
        swPauseReq <= 1'h0;
        idle(20);
        chk(mac.pauseCount, 4);
        rxFifoLevel <= 14'h0000;
        idle(5);
        txEnable <= 1'h1;
        swPauseReq <= 1'h1;
        idle(1);
        swPauseReq <= 1'h0;
        idle(20);
        chk(mac.pauseCount, 5);
        chk(mac.lastTime, 32'h1234);
        $display("TEST full duplex done");
        // Half duplex back pressure per selection and duration
        fullDuplex <= 1'h0;
        rxFifoLevel <= 14'h0100;
        for (i = 0; i < 7; i++)
        begin
            txEnable <= TXE[i];
            speed100 <= SPD[i];
            axiWrite(CFG, {16'h0004, 8'h02, CFGB[i]}, 4'hF, afc_pkg::RESP_OKAY);
            mac.sendFrame(KIND[i]);
            jamLen(n);
            chk(n >= (TICKS[i] - 1) * 10 && n <= TICKS[i] * 10 + 2, 1'h1);
        end
        $display("TEST half duplex done");
        stop_test();
    end
endmodule : auto_flow_control_bench
